// *** pkg/eel_map.svh ***
// register offsets, field layout, reset values and counts of the line controller
// assumes byte addresses on a 32-bit register port, one aligned word per register
`ifndef EEL_MAP_SVH
`define EEL_MAP_SVH

// ----------------------------------------
// counts
// ----------------------------------------
`define EEL_NUM_LINES    32
`define EEL_NUM_EXT      16
`define EEL_NUM_PERIPH   15
`define EEL_NUM_PINS     88
`define EEL_SEL_W        7
`define EEL_SEL_STRIDE   8
`define EEL_SEL_PER_REG  4
`define EEL_NUM_SEL_REGS 4
`define EEL_SUPPLY_LINE  31

// ----------------------------------------
// register offsets
// ----------------------------------------
`define EEL_OFS_IMASK    8'h00
`define EEL_OFS_EMASK    8'h04
`define EEL_OFS_RISE     8'h08
`define EEL_OFS_FALL     8'h0C
`define EEL_OFS_PEND     8'h10
`define EEL_OFS_SWTRIG   8'h14
`define EEL_OFS_LEVEL    8'h18
`define EEL_OFS_SEL0     8'h1C

// ----------------------------------------
// reset values and field masks
// ----------------------------------------
`define EEL_RST_MASK     32'h0000_0000
`define EEL_RST_TRIG     32'h0000_0000
`define EEL_RST_PEND     32'h0000_0000
`define EEL_RST_SEL      32'h0000_0000
`define EEL_SEL_MASK     32'h7F7F_7F7F
`define EEL_ZERO         32'h0000_0000

`endif

// *** pkg/eel_pkg.sv ***
// types shared by the line controller files
// assumes eel_map.svh supplies the counts
`default_nettype none
`include "eel_map.svh"
package eel_pkg;
   typedef logic [31:0]                    eel_word_t;
   typedef logic [7:0]                     eel_addr_t;
   typedef logic [`EEL_NUM_LINES-1:0]      eel_lines_t;
   typedef logic [`EEL_SEL_W-1:0]          eel_sel_t;
endpackage
`default_nettype wire

// *** logic/eel_edge_catch.sv ***
// one line's edge catcher: toggles clocked by the source, then a clocked detector
// assumes src_i may be asynchronous and may pulse shorter than one mclk period
`timescale 1ns/100ps
`default_nettype none
module eel_edge_catch (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_n_i,
   // source
   input  wire logic src_i,
   // detected edges and level
   output logic      rise_o,
   output logic      fall_o,
   output logic      level_o
);
   import eel_pkg::*;

   logic rise_tgl;
   logic fall_tgl;
   logic rise_s1, rise_s2, rise_seen;
   logic fall_s1, fall_s2, fall_seen;
   logic lvl_s1,  lvl_s2;
   logic next_rise, next_fall;

   // ----------------------------------------
   // asynchronous capture
   // ----------------------------------------
   // the source itself clocks these, so a pulse narrower than mclk still flips them
   always_ff @(posedge src_i or negedge reset_n_i) begin
      if (!reset_n_i) rise_tgl <= 1'b0;
      else            rise_tgl <= ~rise_tgl; // RQ5
   end

   always_ff @(negedge src_i or negedge reset_n_i) begin
      if (!reset_n_i) fall_tgl <= 1'b0;
      else            fall_tgl <= ~fall_tgl; // RQ5
   end

   // ----------------------------------------
   // synchronise and detect
   // ----------------------------------------
   always_comb begin
      next_rise = rise_s2 ^ rise_seen;
      next_fall = fall_s2 ^ fall_seen;
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         rise_s1   <= 1'b0;
         rise_s2   <= 1'b0;
         rise_seen <= 1'b0;
         fall_s1   <= 1'b0;
         fall_s2   <= 1'b0;
         fall_seen <= 1'b0;
         lvl_s1    <= 1'b0;
         lvl_s2    <= 1'b0;
         rise_o    <= 1'b0;
         fall_o    <= 1'b0;
      end else begin
         rise_s1   <= rise_tgl;
         rise_s2   <= rise_s1;
         rise_seen <= rise_s2;
         fall_s1   <= fall_tgl;
         fall_s2   <= fall_s1;
         fall_seen <= fall_s2;
         lvl_s1    <= src_i;
         lvl_s2    <= lvl_s1;
         rise_o    <= next_rise;
         fall_o    <= next_fall;
      end
   end

   assign level_o = lvl_s2;
endmodule
`default_nettype wire

// *** logic/eel_pin_select.sv ***
// routes one of the general-purpose pins onto each external line
// assumes select values at or above the pin count pick a constant low
`timescale 1ns/100ps
`default_nettype none
`include "eel_map.svh"
module eel_pin_select #(
   parameter int N_PINS = `EEL_NUM_PINS,
   parameter int N_EXT  = `EEL_NUM_EXT,
   parameter int SEL_W  = `EEL_SEL_W
) (
   // pins and selects
   input  wire logic [N_PINS-1:0]      pin_i,
   input  wire logic [N_EXT*SEL_W-1:0] sel_i,
   // routed lines
   output logic      [N_EXT-1:0]       line_o
);
   import eel_pkg::*;

   function automatic logic pick(input logic [N_PINS-1:0] p, input logic [SEL_W-1:0] s);
      logic r;
      r = 1'b0;
      if (int'(s) < N_PINS) r = p[s];
      return r;
   endfunction

   // plain mux ahead of the catchers: a select change can itself look like an edge
   always_comb begin
      line_o = '0;
      for (int i = 0; i < N_EXT; i++) begin
         line_o[i] = pick(pin_i, sel_i[i*SEL_W +: SEL_W]); // RQ6
      end
   end
endmodule
`default_nettype wire

// *** logic/eel_line_ctrl.sv ***
// edge and event line controller: 32 lines, trigger select, masks, pending, wakeup
// assumes a one-cycle-read register port on mclk_i and asynchronous line sources
`timescale 1ns/100ps
`default_nettype none
`include "eel_map.svh"

// Behaviour
// RQ1: there are 32 independent lines, each able to raise an interrupt, an event and a wakeup.
// RQ2: each line selects rising edges, falling edges or both through its own enable bits.
// RQ3: each line has its own mask bits that stop a detected edge from being forwarded.
// RQ4: a selected edge sets the line's pending bit, which holds until software clears it.
// RQ5: edges are latched asynchronously so pulses shorter than one clock period still count.
// RQ6: sixteen lines are external, each routed from one of up to 88 general-purpose pins.
// RQ7: line 31 is fed by the secondary I/O supply monitor comparator.
// RQ8: a triggered request on any line raises the stop-mode wakeup request; the code raises wakeup_o only for unmasked interrupt or event requests.
// RQ9: software clears a pending bit by writing one to it, and a zero leaves it alone.
module eel_line_ctrl #(
   parameter int N_PINS = `EEL_NUM_PINS,
   parameter int N_EXT  = `EEL_NUM_EXT
) (
   // clock and reset
   input  wire logic                 mclk_i,
   input  wire logic                 reset_n_i,
   // register port
   input  wire eel_pkg::eel_addr_t   reg_addr_i,
   input  wire eel_pkg::eel_word_t   reg_wdata_i,
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   output eel_pkg::eel_word_t        reg_rdata_o,
   // line sources
   input  wire logic [N_PINS-1:0]    gpio_pin_i,
   input  wire logic [`EEL_NUM_PERIPH-1:0] periph_src_i,
   input  wire logic                 supply_cmp_i,
   // requests
   output eel_pkg::eel_lines_t       irq_line_o,
   output eel_pkg::eel_lines_t       event_o,
   output logic                      irq_o,
   output logic                      wakeup_o
);
   import eel_pkg::*;

   localparam int NL     = `EEL_NUM_LINES;
   localparam int SEL_W  = `EEL_SEL_W;
   localparam int NSEL   = `EEL_NUM_SEL_REGS;
   localparam int PERREG = `EEL_SEL_PER_REG;
   localparam int STRIDE = `EEL_SEL_STRIDE;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic hit_ofs(input eel_addr_t a, input eel_addr_t ofs);
      return a == ofs;
   endfunction

   function automatic eel_addr_t sel_ofs(input int idx);
      return eel_addr_t'(`EEL_OFS_SEL0 + 4 * idx);
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   eel_lines_t imask, next_imask;
   eel_lines_t emask, next_emask;
   eel_lines_t rise_en, next_rise_en;
   eel_lines_t fall_en, next_fall_en;
   eel_lines_t pend, next_pend;
   eel_word_t  sel_reg      [NSEL];
   eel_word_t  next_sel_reg [NSEL];
   eel_word_t  next_rdata;
   eel_lines_t next_irq_line;
   eel_lines_t next_event;
   logic       next_irq;
   logic       next_wake;

   // ----------------------------------------
   // line sources and edge catchers
   // ----------------------------------------
   logic [N_EXT*SEL_W-1:0] sel_flat;
   logic [N_EXT-1:0]       ext_line;
   eel_lines_t             src;
   eel_lines_t             rise_det;
   eel_lines_t             fall_det;
   eel_lines_t             level;

   always_comb begin
      sel_flat = '0;
      for (int i = 0; i < N_EXT; i++) begin
         sel_flat[i*SEL_W +: SEL_W] = sel_reg[i / PERREG][(i % PERREG)*STRIDE +: SEL_W];
      end
   end

   eel_pin_select #(
      .N_PINS (N_PINS),
      .N_EXT  (N_EXT),
      .SEL_W  (SEL_W)
   ) u_pin_select (
      .pin_i  (gpio_pin_i),
      .sel_i  (sel_flat),
      .line_o (ext_line)
   );

   // lines 0..15 external, 16..30 peripheral, 31 supply comparator
   assign src = {supply_cmp_i, periph_src_i, ext_line}; // RQ6 RQ7

   for (genvar g = 0; g < NL; g++) begin : g_line
      eel_edge_catch u_catch (
         .mclk_i    (mclk_i),
         .reset_n_i (reset_n_i),
         .src_i     (src[g]),
         .rise_o    (rise_det[g]),
         .fall_o    (fall_det[g]),
         .level_o   (level[g])
      ); // RQ1 RQ5
   end

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   logic            at_imask;
   logic            at_emask;
   logic            at_rise;
   logic            at_fall;
   logic            at_pend;
   logic            at_swtrig;
   logic            at_level;
   logic [NSEL-1:0] at_sel;

   // unmapped offsets match nothing: such writes drop and such reads give zero
   always_comb begin
      at_imask  = hit_ofs(reg_addr_i, `EEL_OFS_IMASK);
      at_emask  = hit_ofs(reg_addr_i, `EEL_OFS_EMASK);
      at_rise   = hit_ofs(reg_addr_i, `EEL_OFS_RISE);
      at_fall   = hit_ofs(reg_addr_i, `EEL_OFS_FALL);
      at_pend   = hit_ofs(reg_addr_i, `EEL_OFS_PEND);
      at_swtrig = hit_ofs(reg_addr_i, `EEL_OFS_SWTRIG);
      at_level  = hit_ofs(reg_addr_i, `EEL_OFS_LEVEL);
      at_sel    = '0;
      for (int i = 0; i < NSEL; i++) begin
         at_sel[i] = hit_ofs(reg_addr_i, sel_ofs(i));
      end
   end

   // ----------------------------------------
   // write strobes
   // ----------------------------------------
   logic            wr_imask;
   logic            wr_emask;
   logic            wr_rise;
   logic            wr_fall;
   logic            wr_pend;
   logic            wr_swtrig;
   logic [NSEL-1:0] wr_sel;

   always_comb begin
      wr_imask  = reg_wr_i && at_imask;
      wr_emask  = reg_wr_i && at_emask;
      wr_rise   = reg_wr_i && at_rise;
      wr_fall   = reg_wr_i && at_fall;
      wr_pend   = reg_wr_i && at_pend;
      wr_swtrig = reg_wr_i && at_swtrig;
      wr_sel    = reg_wr_i ? at_sel : '0;
   end

   // ----------------------------------------
   // masks
   // ----------------------------------------
   always_comb begin
      next_imask = imask;
      next_emask = emask;
      if (wr_imask) next_imask = reg_wdata_i; // RQ3
      if (wr_emask) next_emask = reg_wdata_i; // RQ3
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         imask <= `EEL_RST_MASK;
         emask <= `EEL_RST_MASK;
      end else begin
         imask <= next_imask;
         emask <= next_emask;
      end
   end

   // ----------------------------------------
   // trigger selection
   // ----------------------------------------
   // both enables set gives both edges, neither gives none
   always_comb begin
      next_rise_en = rise_en;
      next_fall_en = fall_en;
      if (wr_rise) next_rise_en = reg_wdata_i; // RQ2
      if (wr_fall) next_fall_en = reg_wdata_i; // RQ2
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         rise_en <= `EEL_RST_TRIG;
         fall_en <= `EEL_RST_TRIG;
      end else begin
         rise_en <= next_rise_en;
         fall_en <= next_fall_en;
      end
   end

   // ----------------------------------------
   // pin selects
   // ----------------------------------------
   // bit 7 of each field is not stored and reads back as zero
   // a select change can itself look like an edge on the line
   always_comb begin
      for (int i = 0; i < NSEL; i++) begin
         next_sel_reg[i] = sel_reg[i];
         if (wr_sel[i]) next_sel_reg[i] = reg_wdata_i & `EEL_SEL_MASK; // RQ6
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < NSEL; i++) begin
            sel_reg[i] <= `EEL_RST_SEL;
         end
      end else begin
         for (int i = 0; i < NSEL; i++) begin
            sel_reg[i] <= next_sel_reg[i];
         end
      end
   end

   // ----------------------------------------
   // line events
   // ----------------------------------------
   eel_lines_t edge_hit;
   eel_lines_t sw_hit;
   eel_lines_t clr;
   eel_lines_t hit;

   always_comb begin
      edge_hit = (rise_det & rise_en) | (fall_det & fall_en); // RQ2
      sw_hit   = wr_swtrig ? reg_wdata_i : `EEL_ZERO;
      hit      = edge_hit | sw_hit;
   end

   // ----------------------------------------
   // pending
   // ----------------------------------------
   always_comb begin
      clr       = wr_pend ? reg_wdata_i : `EEL_ZERO; // RQ9
      // pending sets whatever the masks say; masks only gate forwarding
      // a new edge beats a clear in the same cycle
      next_pend = (pend & ~clr) | hit; // RQ4 RQ9
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) pend <= `EEL_RST_PEND;
      else            pend <= next_pend;
   end

   // ----------------------------------------
   // requests
   // ----------------------------------------
   always_comb begin
      next_irq_line = next_pend & imask; // RQ3
      next_event    = hit & emask; // RQ3
      next_irq      = |next_irq_line; // RQ1
      // needs mclk; the catchers hold edges while the clock is stopped
      next_wake     = (|next_irq_line) | (|next_event); // RQ8
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         irq_line_o <= `EEL_ZERO;
         event_o    <= `EEL_ZERO;
         irq_o      <= 1'b0;
         wakeup_o   <= 1'b0;
      end else begin
         irq_line_o <= next_irq_line;
         event_o    <= next_event;
         irq_o      <= next_irq;
         wakeup_o   <= next_wake;
      end
   end

   // ----------------------------------------
   // register reads
   // ----------------------------------------
   // data stands only in the cycle after the strobe; unmapped reads give zero
   always_comb begin
      next_rdata = `EEL_ZERO;
      if (reg_rd_i) begin
         if (at_imask) next_rdata = imask;
         if (at_emask) next_rdata = emask;
         if (at_rise)  next_rdata = rise_en;
         if (at_fall)  next_rdata = fall_en;
         if (at_pend)  next_rdata = pend;
         if (at_level) next_rdata = level;
         for (int i = 0; i < NSEL; i++) begin
            if (at_sel[i]) next_rdata = sel_reg[i];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) reg_rdata_o <= `EEL_ZERO;
      else            reg_rdata_o <= next_rdata;
   end
endmodule
`default_nettype wire

// *** tb/eel_core_model.sv ***
// core-side model: counts event pulses and notes any wakeup request
// assumes requests are sampled on the controller clock
`timescale 1ns/100ps
`default_nettype none
module eel_core_model (
   // clock and reset
   input  wire logic                mclk_i,
   input  wire logic                reset_n_i,
   // requests from the controller
   input  wire eel_pkg::eel_lines_t evt_i,
   input  wire logic                wake_i,
   // what the core has seen
   output var  logic [7:0]          evt_cnt_o,
   output var  logic                wake_seen_o
);
   import eel_pkg::*;
   logic [7:0] next_cnt;
   logic       next_seen;
   // a pulse on several lines at once counts once per line
   always_comb begin
      next_cnt  = evt_cnt_o + 8'($countones(evt_i));
      next_seen = wake_seen_o | wake_i;
   end
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         evt_cnt_o   <= 8'h00;
         wake_seen_o <= 1'b0;
      end else begin
         evt_cnt_o   <= next_cnt;
         wake_seen_o <= next_seen;
      end
   end
endmodule
`default_nettype wire

// *** tb/eel_chk.sv ***
// port checker of the line controller, bound onto every instance
// assumes one clock; the interrupt mask is tracked from register writes
`timescale 1ns/100ps
`default_nettype none
`include "eel_map.svh"
module eel_chk (
   // clock and reset
   input  wire logic                mclk_i,
   input  wire logic                reset_n_i,
   // register port
   input  wire eel_pkg::eel_addr_t  reg_addr_i,
   input  wire eel_pkg::eel_word_t  reg_wdata_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   input  wire eel_pkg::eel_word_t  reg_rdata_o,
   // requests
   input  wire eel_pkg::eel_lines_t irq_line_o,
   input  wire eel_pkg::eel_lines_t event_o,
   input  wire logic                irq_o,
   input  wire logic                wakeup_o
);
   import eel_pkg::*;
   eel_word_t imask;
   eel_word_t next_imask;
   always_comb begin
      next_imask = imask;
      if (reg_wr_i && reg_addr_i == `EEL_OFS_IMASK)
         next_imask = reg_wdata_i;
   end
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i)
         imask <= `EEL_RST_MASK;
      else
         imask <= next_imask;
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   a_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == `EEL_ZERO)
      else $error("read data not zero outside a read");
   a_rd_mask: assert property (reg_rd_i && reg_addr_i == `EEL_OFS_IMASK |=>
      reg_rdata_o == $past(imask)) else $error("mask read back wrong");
   a_irq_any: assert property (irq_o == |irq_line_o)
      else $error("summary interrupt differs from lines");
   a_wake_any: assert property (wakeup_o == (|irq_line_o || |event_o))
      else $error("wakeup differs from requests");
   a_line_masked: assert property ((irq_line_o & ~$past(imask)) == `EEL_ZERO)
      else $error("masked line forwarded");
   // a clear drops a line one edge later, a mask write two edges later
   a_pend_hold: assert property (|($past(irq_line_o) & ~irq_line_o) |->
      ($past(reg_wr_i) && $past(reg_addr_i) == `EEL_OFS_PEND)
      || ($past(reg_wr_i, 2) && $past(reg_addr_i, 2) == `EEL_OFS_IMASK))
      else $error("line dropped without clear");
   a_swtrig_set: assert property (reg_wr_i && reg_addr_i == `EEL_OFS_SWTRIG |=>
      ($past(reg_wdata_i) & $past(imask) & ~irq_line_o) == `EEL_ZERO)
      else $error("software trigger not raised");
   // an edge in the clear cycle wins; seen on event_o only while events are unmasked
   a_clr_drop: assert property (reg_wr_i && reg_addr_i == `EEL_OFS_PEND |=>
      (irq_line_o & ~event_o & $past(reg_wdata_i)) == `EEL_ZERO)
      else $error("clear not taken");
endmodule
bind eel_line_ctrl eel_chk eel_chk_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_line_o(irq_line_o),
   .event_o(event_o), .irq_o(irq_o), .wakeup_o(wakeup_o));
`default_nettype wire

// *** tb/eel_line_ctrl_tb.sv ***
// self-checking bench: register port, line edges, masks, software trigger
// assumes the checker binds itself onto the controller
`timescale 1ns/100ps
`default_nettype none
`include "eel_map.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
   $display("ERROR %0t: got %h want %h", $time, a, e); end end
module eel_line_ctrl_tb;
   import eel_pkg::*;
   localparam eel_word_t L16 = 32'h0001_0000;
   logic                         mclk_i = 1'b0;
   logic                         reset_n_i = 1'b0;
   eel_addr_t                    reg_addr_i = 8'h00;
   eel_word_t                    reg_wdata_i = 32'h0000_0000;
   logic                         reg_wr_i = 1'b0;
   logic                         reg_rd_i = 1'b0;
   logic [`EEL_NUM_PINS-1:0]     gpio_pin_i = '0;
   logic [`EEL_NUM_PERIPH-1:0]   periph_src_i = '0;
   logic                         supply_cmp_i = 1'b0;
   eel_word_t                    reg_rdata_o;
   eel_lines_t                   irq_line_o;
   eel_lines_t                   event_o;
   logic                         irq_o;
   logic                         wakeup_o;
   logic [7:0]                   evt_cnt;
   logic [7:0]                   c0;
   logic                         wake_seen;
   logic                         rd_seen = 1'b0;
   eel_word_t                    exp_q[$];
   eel_word_t                    v;
   eel_word_t                    got;
   eel_addr_t                    a;
   int                           p;
   int                           err_total = 0;
   int                           compares = 0;
   int                           seed = 87;
   eel_line_ctrl eel_line_ctrl_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .gpio_pin_i(gpio_pin_i),
      .periph_src_i(periph_src_i), .supply_cmp_i(supply_cmp_i), .irq_line_o(irq_line_o),
      .event_o(event_o), .irq_o(irq_o), .wakeup_o(wakeup_o));
   eel_core_model eel_core_model_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .evt_i(event_o), .wake_i(wakeup_o), .evt_cnt_o(evt_cnt), .wake_seen_o(wake_seen));
   always #10 mclk_i = ~mclk_i;
   // read data stand one cycle only, so they are taken mid-cycle
   always @(posedge mclk_i) rd_seen <= reg_rd_i;
   always @(negedge mclk_i) begin
      if (rd_seen) begin
         got = exp_q.pop_front();
         `CHK(reg_rdata_o, got)
      end
   end
   task automatic bus(input logic w, input logic r, input eel_addr_t ad, input eel_word_t d);
      reg_wr_i <= w;
      reg_rd_i <= r;
      reg_addr_i <= ad;
      reg_wdata_i <= d;
      @(posedge mclk_i);
   endtask
   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 8'h00, `EEL_ZERO);
   endtask
   task automatic wr(input eel_addr_t ad, input eel_word_t d);
      bus(1'b1, 1'b0, ad, d);
   endtask
   task automatic rd(input eel_addr_t ad, input eel_word_t e);
      exp_q.push_back(e);
      bus(1'b0, 1'b1, ad, `EEL_ZERO);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #100us;
      err_total++;
      tally_and_finish();
   end
   initial begin
      repeat (8) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      idle(1);
      `CHK(wake_seen, 1'b0)
      for (int i = 0; i < 12; i++) rd(8'(i * 4), `EEL_ZERO);
      for (int i = 0; i < 8; i++) begin
         a = (i < 4) ? 8'(i * 4) : 8'(`EEL_OFS_SEL0 + (i - 4) * 4);
         v = $random(seed);
         wr(a, v);
         rd(a, (i < 4) ? v : v & `EEL_SEL_MASK);
      end
      $display("test registers done");
      wr(`EEL_OFS_IMASK, ~`EEL_ZERO);
      wr(`EEL_OFS_EMASK, ~`EEL_ZERO);
      for (int m = 0; m < 4; m++) begin
         wr(`EEL_OFS_RISE, m[0] ? L16 : `EEL_ZERO);
         wr(`EEL_OFS_FALL, m[1] ? L16 : `EEL_ZERO);
         periph_src_i[0] <= 1'b1;
         idle(6);
         `CHK(irq_line_o, m[0] ? L16 : `EEL_ZERO)
         `CHK(wakeup_o, m[0])
         rd(`EEL_OFS_PEND, m[0] ? L16 : `EEL_ZERO);
         wr(`EEL_OFS_PEND, ~`EEL_ZERO);
         periph_src_i[0] <= 1'b0;
         idle(6);
         rd(`EEL_OFS_PEND, m[1] ? L16 : `EEL_ZERO);
         wr(`EEL_OFS_PEND, ~`EEL_ZERO);
      end
      $display("test trigger modes done");
      c0 = evt_cnt;
      v = $random(seed);
      wr(`EEL_OFS_SWTRIG, v);
      rd(`EEL_OFS_PEND, v);
      rd(`EEL_OFS_SWTRIG, `EEL_ZERO);
      idle(1);
      `CHK(evt_cnt, 8'(c0 + $countones(v)))
      wr(`EEL_OFS_PEND, v);
      wr(`EEL_OFS_IMASK, `EEL_ZERO);
      wr(`EEL_OFS_EMASK, `EEL_ZERO);
      c0 = evt_cnt;
      wr(`EEL_OFS_SWTRIG, L16);
      idle(2);
      `CHK(irq_o, 1'b0)
      `CHK(evt_cnt, c0)
      wr(`EEL_OFS_PEND, `EEL_ZERO);
      wr(`EEL_OFS_IMASK, L16);
      idle(2);
      `CHK(irq_o, 1'b1)
      rd(`EEL_OFS_PEND, L16);
      wr(`EEL_OFS_PEND, L16);
      idle(2);
      `CHK(irq_o, 1'b0)
      $display("test masks done");
      p = int'({$random(seed)} % `EEL_NUM_PINS);
      wr(`EEL_OFS_SEL0, 32'(p));
      wr(`EEL_OFS_RISE, 32'h8000_0001);
      wr(`EEL_OFS_IMASK, ~`EEL_ZERO);
      // pulse far shorter than a clock period
      gpio_pin_i[p] <= 1'b1;
      supply_cmp_i <= 1'b1;
      #4;
      gpio_pin_i[p] <= 1'b0;
      @(posedge mclk_i);
      idle(6);
      rd(`EEL_OFS_PEND, 32'h8000_0001);
      rd(`EEL_OFS_LEVEL, 32'h8000_0000);
      `CHK(wakeup_o, 1'b1)
      wr(`EEL_OFS_PEND, ~`EEL_ZERO);
      idle(2);
      `CHK(wake_seen, 1'b1)
      $display("test short pulse done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
